// File: rtl/uart_irq_ctrl.sv
/*
 * Interrupt enable, FIFO control and interrupt identity logic of a serial
 * port, reached over classic Wishbone, driving the host interrupt line
 * and the receive and transmit DMA request outputs.
 * Assumes the shifter and FIFOs live outside and report their state on
 * the status inputs, all synchronous to clk_i.
 */
// Chosen here: the Wishbone slave port.
`timescale 1ns/100ps

module uart_irq_ctrl #(
	parameter int FIFO_DEPTH = 16,
	parameter int CNT_W = 5
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [5:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// Status from the rest of the port
	input wire uart_irq_pkg::line_err_t line_err_i,
	input wire uart_irq_pkg::modem_delta_t modem_delta_i,
	input wire logic rx_ready_flag_i,
	input wire logic tx_buffer_empty_flag_i,
	input wire logic [CNT_W-1:0] rx_count_i,
	input wire logic [CNT_W-1:0] tx_count_i,
	input wire logic rx_activity_i,
	input wire logic char_tick_i,
	// Host interrupt pin, three-state
	output logic host_interrupt_line_o,
	output logic host_interrupt_line_oe_o,
	// DMA handshakes
	output logic rx_dma_request_o,
	output logic tx_dma_request_o,
	// Controls and access strobes to the rest of the port
	output logic fifo_mode_o,
	output logic [CNT_W-1:0] rx_trigger_o,
	output logic rx_fifo_clear_o,
	output logic tx_fifo_clear_o,
	output logic rx_buffer_read_o,
	output logic tx_buffer_write_o,
	output logic line_status_read_o,
	output logic modem_status_read_o
);
	logic [3:0] interrupt_enable_reg;
	logic fifo_en_reg;
	logic dma_sel_reg;
	logic [1:0] trig_reg;
	logic div_sel_reg;
	logic out2_reg;
	logic line_pend_reg;
	logic tx_pend_reg;
	logic tx_seen_reg;
	uart_irq_pkg::line_err_t line_prev_reg;
	logic [2:0] tmo_cnt_reg;
	uart_irq_pkg::irq_src_t snap_reg;
	uart_irq_pkg::irq_src_t live_src;
	logic req, rd, wr, wr_lo;
	logic [3:0] idx;
	logic frozen;
	logic [CNT_W-1:0] trig_cnt;
	logic rx_pend, tmo_pend, modem_pend, line_change, tx_rise;
	logic [7:0] identity_byte;
	logic [7:0] rdata;

	assign idx = adr_i[5:2];
	assign req = cyc_i && stb_i && !ack_o;
	assign rd = req && !we_i;
	assign wr = req && we_i;
	assign wr_lo = wr && sel_i[0];
	// Freeze covers the whole bus cycle, not only the answer edge
	assign frozen = cyc_i && stb_i && !we_i
		&& idx == uart_irq_pkg::IDX_FIFO;
	assign trig_cnt = CNT_W'(uart_irq_pkg::trig_level(trig_reg));

	// Enabled sources; disabling an enable masks the source at once
	assign line_change = line_err_i != line_prev_reg;
	assign modem_pend = interrupt_enable_reg[uart_irq_pkg::EN_MODEM]
		&& |modem_delta_i;
	assign rx_pend = interrupt_enable_reg[uart_irq_pkg::EN_RX]
		&& (fifo_en_reg ? rx_count_i >= trig_cnt
		: rx_ready_flag_i);
	assign tmo_pend = interrupt_enable_reg[uart_irq_pkg::EN_RX]
		&& fifo_en_reg
		&& tmo_cnt_reg == uart_irq_pkg::TIMEOUT_CHARS;
	assign tx_rise = tx_buffer_empty_flag_i
		&& interrupt_enable_reg[uart_irq_pkg::EN_TX] && !tx_seen_reg;

	always_comb begin
		if (line_pend_reg && interrupt_enable_reg[uart_irq_pkg::EN_LINE])
			live_src = uart_irq_pkg::SRC_LINE;
		else if (rx_pend)
			live_src = uart_irq_pkg::SRC_RXDATA;
		else if (tmo_pend)
			live_src = uart_irq_pkg::SRC_TIMEOUT;
		else if (tx_pend_reg && interrupt_enable_reg[uart_irq_pkg::EN_TX])
			live_src = uart_irq_pkg::SRC_TXEMPTY;
		else if (modem_pend)
			live_src = uart_irq_pkg::SRC_MODEM;
		else
			live_src = uart_irq_pkg::SRC_NONE;
	end

	always_comb begin
		identity_byte = {{2{fifo_en_reg}}, 2'h0,
			uart_irq_pkg::src_code(snap_reg)};
		if (!fifo_en_reg)
			identity_byte[3] = 1'b0;
	end

	always_comb begin
		rdata = 8'h00;
		case (idx)
			uart_irq_pkg::IDX_ENABLE: begin
				if (!div_sel_reg)
					rdata = {4'h0, interrupt_enable_reg};
			end
			uart_irq_pkg::IDX_FIFO: rdata = identity_byte;
			uart_irq_pkg::IDX_CTRL: begin
				rdata[uart_irq_pkg::CTRL_DIV] = div_sel_reg;
				rdata[uart_irq_pkg::CTRL_OUT2] = out2_reg;
			end
			uart_irq_pkg::IDX_STAT: rdata = {1'b0, rx_dma_request_o,
				tx_dma_request_o, host_interrupt_line_o,
				fifo_en_reg, dma_sel_reg, trig_reg};
			default: rdata = 8'h00;
		endcase
	end

	// Bus answer: one wait state, unmapped reads return zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= 32'h0000_0000;
		end else begin
			ack_o <= req;
			if (rd)
				dat_o <= {24'h00_0000, rdata};
		end
	end

	// Strobes to the data path and status registers outside
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_buffer_read_o <= 1'b0;
			tx_buffer_write_o <= 1'b0;
			line_status_read_o <= 1'b0;
			modem_status_read_o <= 1'b0;
		end else begin
			rx_buffer_read_o <= rd && !div_sel_reg
				&& idx == uart_irq_pkg::IDX_DATA;
			tx_buffer_write_o <= wr_lo && !div_sel_reg
				&& idx == uart_irq_pkg::IDX_DATA;
			line_status_read_o <= rd && idx == uart_irq_pkg::IDX_LINE;
			modem_status_read_o <= rd && idx == uart_irq_pkg::IDX_MODEM;
		end
	end

	// Enable and own control registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			interrupt_enable_reg <= uart_irq_pkg::EN_RESET;
			div_sel_reg <= 1'b0;
			out2_reg <= 1'b0;
		end else if (wr_lo) begin
			if (idx == uart_irq_pkg::IDX_ENABLE && !div_sel_reg)
				interrupt_enable_reg <= dat_i[3:0];
			if (idx == uart_irq_pkg::IDX_CTRL) begin
				div_sel_reg <= dat_i[uart_irq_pkg::CTRL_DIV];
				out2_reg <= dat_i[uart_irq_pkg::CTRL_OUT2];
			end
		end
	end

	// FIFO control: other bits only act when enable is written as one
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fifo_en_reg <= 1'b0;
			dma_sel_reg <= 1'b0;
			trig_reg <= uart_irq_pkg::TRIG_RESET;
			rx_fifo_clear_o <= 1'b0;
			tx_fifo_clear_o <= 1'b0;
		end else begin
			rx_fifo_clear_o <= 1'b0;
			tx_fifo_clear_o <= 1'b0;
			if (wr_lo && idx == uart_irq_pkg::IDX_FIFO) begin
				fifo_en_reg <= dat_i[uart_irq_pkg::FC_EN];
				if (!dat_i[uart_irq_pkg::FC_EN]) begin
					rx_fifo_clear_o <= 1'b1;
					tx_fifo_clear_o <= 1'b1;
				end else begin
					dma_sel_reg <= dat_i[uart_irq_pkg::FC_DMA];
					trig_reg <= dat_i[uart_irq_pkg::FC_TRIG_LO +: 2];
					rx_fifo_clear_o <= dat_i[uart_irq_pkg::FC_RXCLR];
					tx_fifo_clear_o <= dat_i[uart_irq_pkg::FC_TXCLR];
				end
			end
		end
	end

	// Line error change latch; a new change beats a clearing read
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			line_prev_reg <= '0;
			line_pend_reg <= 1'b0;
		end else begin
			line_prev_reg <= line_err_i;
			if (line_change && interrupt_enable_reg[uart_irq_pkg::EN_LINE])
				line_pend_reg <= 1'b1;
			else if (rd && idx == uart_irq_pkg::IDX_LINE)
				line_pend_reg <= 1'b0;
		end
	end

	// Transmit empty latch, armed by the empty edge while enabled
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_seen_reg <= 1'b0;
			tx_pend_reg <= 1'b0;
		end else begin
			tx_seen_reg <= tx_buffer_empty_flag_i
				&& interrupt_enable_reg[uart_irq_pkg::EN_TX];
			if (tx_rise)
				tx_pend_reg <= 1'b1;
			else if ((wr_lo && !div_sel_reg
				&& idx == uart_irq_pkg::IDX_DATA)
				|| (rd && idx == uart_irq_pkg::IDX_FIFO
				&& snap_reg == uart_irq_pkg::SRC_TXEMPTY))
				tx_pend_reg <= 1'b0;
		end
	end

	// Character timeout counter; any push or pop restarts it
	always_ff @(posedge clk_i) begin
		if (rst_i)
			tmo_cnt_reg <= 3'h0;
		else if (!fifo_en_reg || rx_count_i == '0 || rx_activity_i
			|| rx_buffer_read_o)
			tmo_cnt_reg <= 3'h0;
		else if (char_tick_i && tmo_cnt_reg != uart_irq_pkg::TIMEOUT_CHARS)
			tmo_cnt_reg <= tmo_cnt_reg + 3'h1;
	end

	// Identity snapshot and interrupt pin
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			snap_reg <= uart_irq_pkg::SRC_NONE;
			host_interrupt_line_o <= 1'b0;
			host_interrupt_line_oe_o <= 1'b0;
		end else begin
			if (!frozen)
				snap_reg <= live_src;
			host_interrupt_line_o <= live_src != uart_irq_pkg::SRC_NONE
				&& out2_reg;
			host_interrupt_line_oe_o <= out2_reg;
		end
	end

	// DMA request outputs and mirrored controls
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_dma_request_o <= 1'b0;
			tx_dma_request_o <= 1'b0;
			fifo_mode_o <= 1'b0;
			rx_trigger_o <= '0;
		end else begin
			fifo_mode_o <= fifo_en_reg;
			rx_trigger_o <= trig_cnt;
			if (!fifo_en_reg) begin
				rx_dma_request_o <= rx_ready_flag_i;
				tx_dma_request_o <= tx_buffer_empty_flag_i;
			end else if (dma_sel_reg) begin
				if (rx_count_i == '0)
					rx_dma_request_o <= 1'b0;
				else if (rx_count_i >= trig_cnt
					|| tmo_cnt_reg == uart_irq_pkg::TIMEOUT_CHARS)
					rx_dma_request_o <= 1'b1;
				tx_dma_request_o <= tx_count_i
					< CNT_W'(FIFO_DEPTH);
			end else begin
				rx_dma_request_o <= rx_count_i != '0;
				tx_dma_request_o <= tx_count_i == '0;
			end
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	property p_fifo_off;
		wr_lo && idx == uart_irq_pkg::IDX_FIFO && !dat_i[0]
		|=> !fifo_en_reg && rx_fifo_clear_o && tx_fifo_clear_o;
	endproperty
	a_fifo_off: assert property (p_fifo_off)
		else $error("FIFO disable did not clear both FIFOs");

	property p_ignore_bits;
		wr_lo && idx == uart_irq_pkg::IDX_FIFO && !dat_i[0]
		|=> $stable(dma_sel_reg) && $stable(trig_reg);
	endproperty
	a_ignore_bits: assert property (p_ignore_bits)
		else $error("FIFO control bits changed without enable");

	property p_freeze;
		frozen && $past(frozen) |-> $stable(snap_reg);
	endproperty
	a_freeze: assert property (p_freeze)
		else $error("Identity changed during its read");

	property p_masked;
		interrupt_enable_reg == 4'h0 |=> !host_interrupt_line_o;
	endproperty
	a_masked: assert property (p_masked)
		else $error("Interrupt raised with all sources disabled");

	property p_pin_off;
		!out2_reg |=> !host_interrupt_line_oe_o && !host_interrupt_line_o;
	endproperty
	a_pin_off: assert property (p_pin_off)
		else $error("Interrupt pin driven with out2 clear");

	property p_bit3;
		ack_o && !fifo_en_reg && $past(rd && idx == uart_irq_pkg::IDX_FIFO)
		|-> !dat_o[3] && dat_o[7:4] == 4'h0;
	endproperty
	a_bit3: assert property (p_bit3)
		else $error("Identity bit 3 set outside FIFO mode");

	property p_rx_nondma;
		fifo_en_reg && !dma_sel_reg && rx_count_i != '0
		|=> rx_dma_request_o;
	endproperty
	a_rx_nondma: assert property (p_rx_nondma)
		else $error("Receive request missing in non-DMA mode");

	property p_tx_full;
		fifo_en_reg && dma_sel_reg && tx_count_i == CNT_W'(FIFO_DEPTH)
		|=> !tx_dma_request_o;
	endproperty
	a_tx_full: assert property (p_tx_full)
		else $error("Transmit request held with FIFO full");

	property p_modem;
		interrupt_enable_reg[3] && |modem_delta_i && out2_reg
		|=> host_interrupt_line_o;
	endproperty
	a_modem: assert property (p_modem)
		else $error("Modem change did not raise interrupt");

	property p_line_prio;
		line_pend_reg && interrupt_enable_reg[2] && !frozen
		|=> snap_reg == uart_irq_pkg::SRC_LINE;
	endproperty
	a_line_prio: assert property (p_line_prio)
		else $error("Line status not reported first");
endmodule : uart_irq_ctrl

// File: rtl/uart_irq_pkg.sv
/*
 * Shared constants and types for the serial port interrupt and FIFO
 * control block: register indices, field positions, reset values,
 * identity codes and the carriers for the status inputs.
 * Assumes a 32-bit classic Wishbone bus with one register per word.
 */
package uart_irq_pkg;
	// Register indices; byte address is four times the index
	localparam logic [3:0] IDX_DATA = 4'h0;
	localparam logic [3:0] IDX_ENABLE = 4'h1;
	localparam logic [3:0] IDX_FIFO = 4'h2;
	localparam logic [3:0] IDX_LINE = 4'h5;
	localparam logic [3:0] IDX_MODEM = 4'h6;
	localparam logic [3:0] IDX_CTRL = 4'h8;
	localparam logic [3:0] IDX_STAT = 4'h9;

	// interrupt_enable_reg fields
	localparam int EN_RX = 0;
	localparam int EN_TX = 1;
	localparam int EN_LINE = 2;
	localparam int EN_MODEM = 3;
	localparam logic [3:0] EN_RESET = 4'h0;

	// fifo_control_reg fields
	localparam int FC_EN = 0;
	localparam int FC_RXCLR = 1;
	localparam int FC_TXCLR = 2;
	localparam int FC_DMA = 3;
	localparam int FC_TRIG_LO = 6;
	localparam logic [1:0] TRIG_RESET = 2'h0;

	// Control register fields
	localparam int CTRL_OUT2 = 3;
	localparam int CTRL_DIV = 7;

	// Receive trigger thresholds per code
	localparam logic [4:0] TRIG_LVL_0 = 5'h01;
	localparam logic [4:0] TRIG_LVL_1 = 5'h04;
	localparam logic [4:0] TRIG_LVL_2 = 5'h08;
	localparam logic [4:0] TRIG_LVL_3 = 5'h0e;

	// Identity codes for the low nibble
	localparam logic [3:0] ID_NONE = 4'h1;
	localparam logic [3:0] ID_LINE = 4'h6;
	localparam logic [3:0] ID_RXDATA = 4'h4;
	localparam logic [3:0] ID_TIMEOUT = 4'hc;
	localparam logic [3:0] ID_TXEMPTY = 4'h2;
	localparam logic [3:0] ID_MODEM = 4'h0;

	// Character times of silence before a receive timeout
	localparam logic [2:0] TIMEOUT_CHARS = 3'h4;

	typedef enum logic [2:0] {
		SRC_NONE,
		SRC_LINE,
		SRC_RXDATA,
		SRC_TIMEOUT,
		SRC_TXEMPTY,
		SRC_MODEM
	} irq_src_t;

	typedef struct packed {
		logic break_flag;
		logic framing_fault_flag;
		logic parity_fault_flag;
		logic overrun_flag;
	} line_err_t;

	typedef struct packed {
		logic carrier_change_flag;
		logic ring_trailing_edge_flag;
		logic dsr_change_flag;
		logic cts_change_flag;
	} modem_delta_t;

	function automatic logic [4:0] trig_level(input logic [1:0] code);
		case (code)
			2'h0: trig_level = TRIG_LVL_0;
			2'h1: trig_level = TRIG_LVL_1;
			2'h2: trig_level = TRIG_LVL_2;
			default: trig_level = TRIG_LVL_3;
		endcase
	endfunction : trig_level

	function automatic logic [3:0] src_code(input irq_src_t s);
		case (s)
			SRC_LINE: src_code = ID_LINE;
			SRC_RXDATA: src_code = ID_RXDATA;
			SRC_TIMEOUT: src_code = ID_TIMEOUT;
			SRC_TXEMPTY: src_code = ID_TXEMPTY;
			SRC_MODEM: src_code = ID_MODEM;
			default: src_code = ID_NONE;
		endcase
	endfunction : src_code
endpackage : uart_irq_pkg

// File: testbench/host_bus_model.sv
/*
 * Host processor model: a classic Wishbone master with single-cycle
 * register write and read tasks.
 * Assumes a slave that answers with ack and registered read data.
 */
`timescale 1ns/100ps
module host_bus_model (
	// Clock
	input wire logic clk_i,
	// Wishbone master
	output logic cyc_o,
	output logic stb_o,
	output logic we_o,
	output logic [5:0] adr_o,
	output logic [3:0] sel_o,
	output logic [31:0] dat_o,
	input wire logic [31:0] dat_i,
	input wire logic ack_i
);
	initial begin
		cyc_o = 1'b0;
		stb_o = 1'b0;
		we_o = 1'b0;
		adr_o = 6'h00;
		sel_o = 4'h0;
		dat_o = 32'h0;
	end

	// Request held until ack is sampled; one idle cycle follows
	task automatic access(input logic w, input logic [5:0] a,
		input logic [7:0] wd, output logic [31:0] rd);
		@(posedge clk_i);
		cyc_o <= 1'b1;
		stb_o <= 1'b1;
		we_o <= w;
		adr_o <= a;
		sel_o <= 4'h1;
		dat_o <= {24'h0, wd};
		do @(posedge clk_i); while (ack_i !== 1'b1);
		rd = dat_i;
		cyc_o <= 1'b0;
		stb_o <= 1'b0;
		we_o <= 1'b0;
	endtask : access

	task automatic write_reg(input logic [5:0] a, input logic [7:0] wd);
		logic [31:0] unused;
		access(1'b1, a, wd, unused);
	endtask : write_reg

	task automatic read_reg(input logic [5:0] a, output logic [31:0] rd);
		access(1'b0, a, 8'h00, rd);
	endtask : read_reg
endmodule : host_bus_model

// File: testbench/uart_interrupt_fifo_control_tb.sv
/*
 * Self-checking bench for the interrupt and FIFO control block.
 * Assumes the host model drives the register bus and the bench plays
 * the FIFOs and line status sources.
 */
`timescale 1ns/100ps
module uart_interrupt_fifo_control_tb;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc, stb, we, ack;
	logic [5:0] adr;
	logic [3:0] sel;
	logic [31:0] wdat, rdat, d;
	uart_irq_pkg::line_err_t line_err = 4'h0;
	uart_irq_pkg::modem_delta_t modem = 4'h0;
	logic rx_rdy = 1'b0, tx_emp = 1'b0, rx_act = 1'b0, tick = 1'b0;
	logic [4:0] rx_cnt = 5'h00, tx_cnt = 5'h00, trig;
	logic irq, irq_oe, rx_req, tx_req, fmode, rxclr, txclr;
	logic rx_pop, tx_push, line_rd, modem_rd;
	logic [4:0] lv [4] = '{5'h01, 5'h04, 5'h08, 5'h0e};
	int n_mismatch = 0, comparisons = 0, n_rxclr = 0, n_txclr = 0;
	int n_rx_pop = 0, n_tx_push = 0, n_line_rd = 0, n_modem_rd = 0;

	always #5 clk_i = ~clk_i;

	always @(posedge clk_i) begin
		if (rxclr === 1'b1) n_rxclr++;
		if (txclr === 1'b1) n_txclr++;
		if (rx_pop === 1'b1) n_rx_pop++;
		if (tx_push === 1'b1) n_tx_push++;
		if (line_rd === 1'b1) n_line_rd++;
		if (modem_rd === 1'b1) n_modem_rd++;
	end

	host_bus_model h (.clk_i(clk_i), .cyc_o(cyc), .stb_o(stb), .we_o(we),
		.adr_o(adr), .sel_o(sel), .dat_o(wdat), .dat_i(rdat), .ack_i(ack));

	uart_irq_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
		.stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat),
		.dat_o(rdat), .ack_o(ack), .line_err_i(line_err),
		.modem_delta_i(modem), .rx_ready_flag_i(rx_rdy),
		.tx_buffer_empty_flag_i(tx_emp), .rx_count_i(rx_cnt),
		.tx_count_i(tx_cnt), .rx_activity_i(rx_act), .char_tick_i(tick),
		.host_interrupt_line_o(irq), .host_interrupt_line_oe_o(irq_oe),
		.rx_dma_request_o(rx_req), .tx_dma_request_o(tx_req),
		.fifo_mode_o(fmode), .rx_trigger_o(trig), .rx_fifo_clear_o(rxclr),
		.tx_fifo_clear_o(txclr), .rx_buffer_read_o(rx_pop),
		.tx_buffer_write_o(tx_push), .line_status_read_o(line_rd),
		.modem_status_read_o(modem_rd));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic rc(input logic [5:0] a, input logic [31:0] exp);
		h.read_reg(a, d);
		chk(d, exp);
	endtask : rc

	// Registered outputs need two edges to follow their inputs
	task automatic settle;
		repeat (2) @(posedge clk_i);
	endtask : settle

	task automatic test_end(input string s);
		$display("test %s finished", s);
	endtask : test_end

	task automatic end_of_test;
		$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : end_of_test

	initial begin
		#100000;
		n_mismatch++;
		end_of_test;
	end

	initial begin
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		rc(6'h08, 32'h01);
		rc(6'h04, 32'h00);
		rc(6'h3c, 32'h00);
		test_end("reset");
		h.write_reg(6'h20, 8'h08);
		h.write_reg(6'h04, 8'h0f);
		rc(6'h04, 32'h0f);
		h.write_reg(6'h20, 8'h88);
		h.write_reg(6'h04, 8'h00);
		rc(6'h04, 32'h00);
		h.write_reg(6'h20, 8'h08);
		rc(6'h04, 32'h0f);
		test_end("enable access");
		@(posedge clk_i);
		line_err <= 4'h2;
		modem <= 4'h1;
		rx_rdy <= 1'b1;
		tx_emp <= 1'b1;
		settle;
		chk(irq, 1'b1);
		chk(irq_oe, 1'b1);
		rc(6'h08, 32'h06);
		h.read_reg(6'h14, d);
		rc(6'h08, 32'h04);
		@(posedge clk_i);
		rx_rdy <= 1'b0;
		settle;
		rc(6'h08, 32'h02);
		rc(6'h08, 32'h00);
		h.read_reg(6'h18, d);
		@(posedge clk_i);
		modem <= 4'h0;
		settle;
		rc(6'h08, 32'h01);
		chk(irq, 1'b0);
		test_end("priority");
		h.write_reg(6'h04, 8'h00);
		@(posedge clk_i);
		modem <= 4'h8;
		rx_rdy <= 1'b1;
		line_err <= 4'h0;
		settle;
		rc(6'h08, 32'h01);
		chk(irq, 1'b0);
		@(posedge clk_i);
		modem <= 4'h0;
		rx_rdy <= 1'b0;
		h.write_reg(6'h04, 8'h02);
		settle;
		chk(irq, 1'b1);
		h.write_reg(6'h20, 8'h00);
		settle;
		chk(irq_oe, 1'b0);
		chk(irq, 1'b0);
		h.write_reg(6'h20, 8'h08);
		h.write_reg(6'h00, 8'h55);
		rc(6'h08, 32'h01);
		test_end("masking");
		h.write_reg(6'h04, 8'h00);
		@(posedge clk_i);
		tx_emp <= 1'b0;
		h.write_reg(6'h08, 8'h01);
		rc(6'h08, 32'hc1);
		chk(fmode, 1'b1);
		for (int i = 0; i < 4; i++) begin
			h.write_reg(6'h08, {i[1:0], 6'h01});
			settle;
			chk(trig, lv[i]);
		end
		// Keep trigger code 3 so the ignored write below can be seen
		h.write_reg(6'h08, 8'hc3);
		h.write_reg(6'h08, 8'hc5);
		settle;
		chk(n_rxclr, 1);
		chk(n_txclr, 1);
		h.write_reg(6'h08, 8'h4a);
		settle;
		chk(fmode, 1'b0);
		chk(trig, 5'h0e);
		chk(n_rxclr + n_txclr, 4);
		rc(6'h08, 32'h01);
		@(posedge clk_i);
		rx_cnt <= 5'h04;
		tx_cnt <= 5'h05;
		settle;
		chk({rx_req, tx_req}, 2'h0);
		test_end("fifo control");
		// An empty receive FIFO lets DMA mode start with no request
		@(posedge clk_i);
		rx_cnt <= 5'h00;
		h.write_reg(6'h08, 8'h49);
		@(posedge clk_i);
		rx_cnt <= 5'h03;
		tx_cnt <= 5'h0f;
		settle;
		chk({rx_req, tx_req}, 2'h1);
		@(posedge clk_i);
		rx_cnt <= 5'h04;
		tx_cnt <= 5'h10;
		settle;
		chk({rx_req, tx_req}, 2'h2);
		@(posedge clk_i);
		rx_cnt <= 5'h01;
		settle;
		chk(rx_req, 1'b1);
		@(posedge clk_i);
		rx_cnt <= 5'h00;
		settle;
		chk(rx_req, 1'b0);
		h.write_reg(6'h08, 8'h41);
		@(posedge clk_i);
		rx_cnt <= 5'h01;
		tx_cnt <= 5'h00;
		settle;
		chk({rx_req, tx_req}, 2'h3);
		@(posedge clk_i);
		rx_cnt <= 5'h00;
		tx_cnt <= 5'h01;
		settle;
		chk({rx_req, tx_req}, 2'h0);
		test_end("dma requests");
		h.write_reg(6'h04, 8'h01);
		@(posedge clk_i);
		rx_cnt <= 5'h04;
		settle;
		rc(6'h08, 32'hc4);
		@(posedge clk_i);
		rx_cnt <= 5'h03;
		settle;
		rc(6'h08, 32'hc1);
		repeat (4) begin
			@(posedge clk_i);
			tick <= 1'b1;
			@(posedge clk_i);
			tick <= 1'b0;
		end
		settle;
		rc(6'h08, 32'hcc);
		h.read_reg(6'h00, d);
		// The read pops one byte, as the real FIFO would
		@(posedge clk_i);
		rx_act <= 1'b1;
		rx_cnt <= 5'h02;
		@(posedge clk_i);
		rx_act <= 1'b0;
		settle;
		rc(6'h08, 32'hc1);
		test_end("receive timeout");
		rc(6'h20, 32'h08);
		rc(6'h24, 32'h49);
		chk(n_rx_pop, 1);
		chk(n_tx_push, 1);
		chk(n_line_rd, 1);
		chk(n_modem_rd, 1);
		test_end("strobes");
		end_of_test;
	end
endmodule : uart_interrupt_fifo_control_tb
